//--- hdl/cvr_pkg.sv
// Constants for the capacitance-to-voltage and ADC gain configuration bank
package cvr_pkg;
    // Register indices (word addresses on the register port)
    localparam logic [5:0] ADDR_LOW_EXC = 6'h02;
    localparam logic [5:0] ADDR_AXIS_SEL = 6'h09;
    localparam logic [5:0] ADDR_B_BW = 6'h0d;
    localparam logic [5:0] ADDR_B_POS_OFS = 6'h0e;
    localparam logic [5:0] ADDR_B_NEG_OFS = 6'h0f;
    localparam logic [5:0] ADDR_COMP_LO = 6'h10;
    localparam logic [5:0] ADDR_A_NEG_OFS = 6'h18;
    localparam logic [5:0] ADDR_B_DGAIN = 6'h1a;
    localparam logic [5:0] ADDR_A_GAIN = 6'h1c;
    localparam logic [5:0] ADDR_A_BW = 6'h20;
    localparam logic [5:0] ADDR_A_DGAIN = 6'h24;
    localparam logic [5:0] ADDR_B_GAIN1 = 6'h25;
    localparam logic [5:0] ADDR_EXC_REF = 6'h28;
    localparam logic [5:0] ADDR_A_POS_OFS = 6'h2a;
    localparam logic [5:0] ADDR_B_GAIN2 = 6'h2c;
    // Field positions (lsb) and widths
    localparam int LOW_EXC_LSB = 30;
    localparam int AXIS_SEL_LSB = 18;
    localparam int AXIS_SEL_W = 2;
    localparam int EXC_REF_LSB = 6;
    localparam int EXC_REF_W = 4;
    localparam int GAIN1_W = 4;
    localparam int GAIN2_W = 3;
    localparam int BW_W = 4;
    localparam int OFS_W = 13;
    localparam int DGAIN_W = 20;
    localparam int COMP_W = 8;
    localparam int A_GAIN1_LSB = 22;
    localparam int A_GAIN2_LSB = 26;
    localparam int B_GAIN1_LSB = 27;
    localparam int B_GAIN2_LSB = 2;
    localparam int A_BW_LSB = 24;
    localparam int B_BW_LSB = 4;
    localparam int A_OFS_LSB = 19;
    localparam int B_OFS_LSB = 0;
    localparam int A_DGAIN_LSB = 0;
    localparam int B_DGAIN_LSB = 12;
    localparam int COMP1_LSB = 24;
    localparam int COMP2_LSB = 16;
    localparam int COMP3_LSB = 8;
    localparam int COMP4_LSB = 0;
    localparam int SAMPLE_W = 24;
    localparam int SCALED_W = SAMPLE_W + DGAIN_W;
    // Axis select codes
    localparam logic [1:0] AXIS_FIRST = 2'h1;
    localparam logic [1:0] AXIS_SECOND = 2'h2;
    // Reset values
    localparam logic [1:0] RST_AXIS_SEL = 2'h2;
    localparam logic [3:0] RST_EXC_REF = 4'h0;
    localparam logic [3:0] RST_BW = 4'hf;
    localparam logic [12:0] RST_OFS = 13'h1623;
    localparam logic [19:0] RST_DGAIN = 20'h001f4;
    localparam logic RST_LOW_EXC_INCL = 1'b1;
    localparam logic RST_LOW_EXC_ACCEL = 1'b0;
    localparam logic [3:0] RST_GAIN1_INCL = 4'hb;
    localparam logic [3:0] RST_GAIN1_ACCEL = 4'hc;
    localparam logic [2:0] RST_GAIN2_INCL = 3'h5;
    localparam logic [2:0] RST_GAIN2_ACCEL = 3'h2;
    localparam logic [7:0] RST_COMP = 8'h00;
endpackage

//--- hdl/cvr_field.sv
// One read/write configuration field inside a shared register word
`timescale 1ns/1ns
`default_nettype none
module cvr_field
#(
    parameter int W = 4,
    parameter int LSB = 0,
    parameter logic [5:0] ADDR = 6'h00
)
(
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    // Reset value chosen by the parent
    input wire logic [W-1:0] i_rst_val,
    // Register port write side
    input wire logic i_wr,
    input wire logic [5:0] i_addr,
    input wire logic [31:0] i_wdata,
    // Stored value
    output logic [W-1:0] o_val
);
    logic [W-1:0] val_ff;

    // Synchronous reset loads the variant default; writes hit own word only
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RESETN)
        begin
            val_ff <= i_rst_val;
        end
        else if (i_wr && (i_addr == ADDR))
        begin
            val_ff <= i_wdata[LSB +: W];
        end
    end

    assign o_val = val_ff;
endmodule
`default_nettype wire

//--- hdl/cvr_config_regs.sv
// Front-end configuration register bank with per-axis setting selection
`timescale 1ns/1ns
`default_nettype none
// What this block does
// RULE_01 - Axis code 1 measures the first axis, code 2 the second axis.
// RULE_02 - One axis converted at a time; host switches by rewriting select.
// RULE_03 - Host writes 54,182,182,54 compensation bytes after choosing axis one.
// RULE_04 - Host writes 182,54,54,182 compensation bytes after choosing axis two.
// RULE_05 - Four-bit excitation trim at word 40 bits 9:6, reset zero.
// RULE_06 - Low-excitation flag word 2 bit 30 forces 1.2 V, ignores trim.
// RULE_07 - Low-excitation flag resets 1 for inclinometer, 0 for accelerometer.
// RULE_08 - First gain fields: word 28 bits 25:22 and word 37 bits 30:27.
// RULE_09 - First gain resets 11 inclinometer, 12 accelerometer, per axis.
// RULE_10 - Second gain fields word 28 bits 28:26, word 44 bits 4:2; 5 or 2.
// RULE_11 - Bandwidth fields word 32 bits 27:24, word 13 bits 7:4, reset 15.
// RULE_12 - Host sets bandwidth 4, 8 or 15 following the first gain value.
// RULE_13 - Offset trims 13 bits reset 5667 at words 42/24 and 14/15.
// RULE_14 - Offset trims accept unsigned codes up to 8191.
// RULE_15 - Signed 20-bit digital gains, reset 500, word 36 and word 26.
// RULE_16 - Selected axis sample is multiplied by its signed digital gain.
// RULE_17 - Settings of the selected axis drive the front end outputs.
// RULE_18 - Host uses read-modify-write on shared words.
// RULE_19 - Every field reads back last written value or its reset default.
module cvr_config_regs
import cvr_pkg::*;
(
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    // Variant strap: high for inclinometer, low for accelerometer
    input wire logic I_VARIANT_INCL,
    // Register port
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [5:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    output logic [31:0] O_RDATA,
    output logic O_RVALID,
    // Converted sample of the active axis
    input wire logic I_SAMPLE_VALID,
    input wire logic [23:0] I_SAMPLE,
    output logic O_SCALED_VALID,
    output logic [43:0] O_SCALED,
    // Applied front-end settings
    output logic O_AXIS_SECOND,
    output logic O_EXC_LOW_MODE,
    output logic [3:0] O_EXC_REF_TRIM,
    output logic [3:0] O_GAIN1,
    output logic [2:0] O_GAIN2,
    output logic [3:0] O_BANDWIDTH,
    output logic [12:0] O_POS_OFFSET,
    output logic [12:0] O_NEG_OFFSET,
    output logic [7:0] O_COMP_BYTE_1,
    output logic [7:0] O_COMP_BYTE_2,
    output logic [7:0] O_COMP_BYTE_3,
    output logic [7:0] O_COMP_BYTE_4
);
    //------------------------------------------------------------
    // Field storage
    //------------------------------------------------------------
    logic [0:0] low_excitation_flag;
    logic [1:0] axis_select;
    logic [3:0] excitation_ref_trim;
    logic [3:0] axis_a_first_gain_ctrl;
    logic [3:0] axis_b_first_gain_ctrl;
    logic [2:0] axis_a_second_gain_ctrl;
    logic [2:0] axis_b_second_gain_ctrl;
    logic [3:0] axis_a_bandwidth_ctrl;
    logic [3:0] axis_b_bandwidth_ctrl;
    logic [12:0] axis_a_pos_offset_trim;
    logic [12:0] axis_a_neg_offset_trim;
    logic [12:0] axis_b_pos_offset_trim;
    logic [12:0] axis_b_neg_offset_trim;
    logic [19:0] axis_a_digital_gain;
    logic [19:0] axis_b_digital_gain;
    logic [7:0] parasitic_comp_byte_1;
    logic [7:0] parasitic_comp_byte_2;
    logic [7:0] parasitic_comp_byte_3;
    logic [7:0] parasitic_comp_byte_4;
    logic [0:0] rst_low_exc;
    logic [3:0] rst_gain1;
    logic [2:0] rst_gain2;
    logic sel_second;
    logic [31:0] nxt_rdata;
    logic [31:0] rdata_ff;
    logic rvalid_ff;
    logic signed [43:0] nxt_scaled;
    logic [43:0] scaled_ff;
    logic scaled_valid_ff;
    logic [3:0] exc_trim_ff;
    logic exc_low_ff;

    // Variant defaults
    // RULE_07 low-excitation default
    assign rst_low_exc = I_VARIANT_INCL ? RST_LOW_EXC_INCL : RST_LOW_EXC_ACCEL;
    // RULE_09 first gain default
    assign rst_gain1 = I_VARIANT_INCL ? RST_GAIN1_INCL : RST_GAIN1_ACCEL;
    // RULE_10 second gain default
    assign rst_gain2 = I_VARIANT_INCL ? RST_GAIN2_INCL : RST_GAIN2_ACCEL;

    // RULE_06 low-excitation flag storage
    cvr_field #(.W(1), .LSB(LOW_EXC_LSB), .ADDR(ADDR_LOW_EXC)) u_low_exc (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(rst_low_exc),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(low_excitation_flag));
    // RULE_02 single axis chosen by rewriting select
    cvr_field #(.W(AXIS_SEL_W), .LSB(AXIS_SEL_LSB), .ADDR(ADDR_AXIS_SEL))
    u_axis_sel (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(RST_AXIS_SEL),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(axis_select));
    // RULE_05 excitation trim storage
    cvr_field #(.W(EXC_REF_W), .LSB(EXC_REF_LSB), .ADDR(ADDR_EXC_REF))
    u_exc_ref (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(RST_EXC_REF),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(excitation_ref_trim));
    // RULE_08 first gain fields
    cvr_field #(.W(GAIN1_W), .LSB(A_GAIN1_LSB), .ADDR(ADDR_A_GAIN)) u_a_g1 (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(rst_gain1),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(axis_a_first_gain_ctrl));
    cvr_field #(.W(GAIN1_W), .LSB(B_GAIN1_LSB), .ADDR(ADDR_B_GAIN1)) u_b_g1 (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(rst_gain1),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(axis_b_first_gain_ctrl));
    // RULE_10 second gain fields
    cvr_field #(.W(GAIN2_W), .LSB(A_GAIN2_LSB), .ADDR(ADDR_A_GAIN)) u_a_g2 (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(rst_gain2),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(axis_a_second_gain_ctrl));
    cvr_field #(.W(GAIN2_W), .LSB(B_GAIN2_LSB), .ADDR(ADDR_B_GAIN2)) u_b_g2 (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(rst_gain2),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(axis_b_second_gain_ctrl));
    // RULE_11 bandwidth fields
    cvr_field #(.W(BW_W), .LSB(A_BW_LSB), .ADDR(ADDR_A_BW)) u_a_bw (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(RST_BW),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(axis_a_bandwidth_ctrl));
    cvr_field #(.W(BW_W), .LSB(B_BW_LSB), .ADDR(ADDR_B_BW)) u_b_bw (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(RST_BW),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(axis_b_bandwidth_ctrl));
    // RULE_13 offset trim fields
    // RULE_14 all codes to 8191 accepted
    cvr_field #(.W(OFS_W), .LSB(A_OFS_LSB), .ADDR(ADDR_A_POS_OFS)) u_a_op (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(RST_OFS),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(axis_a_pos_offset_trim));
    cvr_field #(.W(OFS_W), .LSB(A_OFS_LSB), .ADDR(ADDR_A_NEG_OFS)) u_a_on (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(RST_OFS),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(axis_a_neg_offset_trim));
    cvr_field #(.W(OFS_W), .LSB(B_OFS_LSB), .ADDR(ADDR_B_POS_OFS)) u_b_op (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(RST_OFS),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(axis_b_pos_offset_trim));
    cvr_field #(.W(OFS_W), .LSB(B_OFS_LSB), .ADDR(ADDR_B_NEG_OFS)) u_b_on (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(RST_OFS),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(axis_b_neg_offset_trim));
    // RULE_15 digital gain fields
    cvr_field #(.W(DGAIN_W), .LSB(A_DGAIN_LSB), .ADDR(ADDR_A_DGAIN)) u_a_dg (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(RST_DGAIN),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(axis_a_digital_gain));
    cvr_field #(.W(DGAIN_W), .LSB(B_DGAIN_LSB), .ADDR(ADDR_B_DGAIN)) u_b_dg (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(RST_DGAIN),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(axis_b_digital_gain));
    // Compensation bytes; word 15 is shared with the second-axis trim
    cvr_field #(.W(COMP_W), .LSB(COMP1_LSB), .ADDR(ADDR_B_NEG_OFS)) u_c1 (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(RST_COMP),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(parasitic_comp_byte_1));
    cvr_field #(.W(COMP_W), .LSB(COMP2_LSB), .ADDR(ADDR_B_NEG_OFS)) u_c2 (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(RST_COMP),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(parasitic_comp_byte_2));
    cvr_field #(.W(COMP_W), .LSB(COMP3_LSB), .ADDR(ADDR_COMP_LO)) u_c3 (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(RST_COMP),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(parasitic_comp_byte_3));
    cvr_field #(.W(COMP_W), .LSB(COMP4_LSB), .ADDR(ADDR_COMP_LO)) u_c4 (
        .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .i_rst_val(RST_COMP),
        .i_wr(I_WR), .i_addr(I_ADDR), .i_wdata(I_WDATA),
        .o_val(parasitic_comp_byte_4));

    //------------------------------------------------------------
    // Read-back
    //------------------------------------------------------------
    // RULE_19 read returns stored fields, other bits zero
    always_comb
    begin
        nxt_rdata = 32'h00000000;
        unique case (I_ADDR)
            ADDR_LOW_EXC: nxt_rdata[LOW_EXC_LSB] = low_excitation_flag[0];
            ADDR_AXIS_SEL: nxt_rdata[AXIS_SEL_LSB +: AXIS_SEL_W] = axis_select;
            ADDR_EXC_REF:
                nxt_rdata[EXC_REF_LSB +: EXC_REF_W] = excitation_ref_trim;
            ADDR_A_GAIN:
            begin
                nxt_rdata[A_GAIN1_LSB +: GAIN1_W] = axis_a_first_gain_ctrl;
                nxt_rdata[A_GAIN2_LSB +: GAIN2_W] = axis_a_second_gain_ctrl;
            end
            ADDR_B_GAIN1:
                nxt_rdata[B_GAIN1_LSB +: GAIN1_W] = axis_b_first_gain_ctrl;
            ADDR_B_GAIN2:
                nxt_rdata[B_GAIN2_LSB +: GAIN2_W] = axis_b_second_gain_ctrl;
            ADDR_A_BW: nxt_rdata[A_BW_LSB +: BW_W] = axis_a_bandwidth_ctrl;
            ADDR_B_BW: nxt_rdata[B_BW_LSB +: BW_W] = axis_b_bandwidth_ctrl;
            ADDR_A_POS_OFS:
                nxt_rdata[A_OFS_LSB +: OFS_W] = axis_a_pos_offset_trim;
            ADDR_A_NEG_OFS:
                nxt_rdata[A_OFS_LSB +: OFS_W] = axis_a_neg_offset_trim;
            ADDR_B_POS_OFS:
                nxt_rdata[B_OFS_LSB +: OFS_W] = axis_b_pos_offset_trim;
            ADDR_B_NEG_OFS:
            begin
                nxt_rdata[B_OFS_LSB +: OFS_W] = axis_b_neg_offset_trim;
                nxt_rdata[COMP1_LSB +: COMP_W] = parasitic_comp_byte_1;
                nxt_rdata[COMP2_LSB +: COMP_W] = parasitic_comp_byte_2;
            end
            ADDR_COMP_LO:
            begin
                nxt_rdata[COMP3_LSB +: COMP_W] = parasitic_comp_byte_3;
                nxt_rdata[COMP4_LSB +: COMP_W] = parasitic_comp_byte_4;
            end
            ADDR_A_DGAIN:
                nxt_rdata[A_DGAIN_LSB +: DGAIN_W] = axis_a_digital_gain;
            ADDR_B_DGAIN:
                nxt_rdata[B_DGAIN_LSB +: DGAIN_W] = axis_b_digital_gain;
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    // Read data registered one cycle after the strobe
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RESETN)
        begin
            rdata_ff <= 32'h00000000;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rvalid_ff <= I_RD;
            if (I_RD)
            begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    //------------------------------------------------------------
    // Applied settings
    //------------------------------------------------------------
    // RULE_01 code 2 picks the second axis; other codes fall to the first
    assign sel_second = (axis_select == AXIS_SECOND);

    // RULE_06 low mode masks the trim so it cannot steer the reference
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RESETN)
        begin
            exc_low_ff <= 1'b0;
            exc_trim_ff <= RST_EXC_REF;
        end
        else
        begin
            exc_low_ff <= low_excitation_flag[0];
            exc_trim_ff <= low_excitation_flag[0] ? RST_EXC_REF
                : excitation_ref_trim;
        end
    end

    // RULE_17 settings muxed from the selected axis
    assign O_GAIN1 = sel_second ? axis_b_first_gain_ctrl
        : axis_a_first_gain_ctrl;
    assign O_GAIN2 = sel_second ? axis_b_second_gain_ctrl
        : axis_a_second_gain_ctrl;
    assign O_BANDWIDTH = sel_second ? axis_b_bandwidth_ctrl
        : axis_a_bandwidth_ctrl;
    assign O_POS_OFFSET = sel_second ? axis_b_pos_offset_trim
        : axis_a_pos_offset_trim;
    assign O_NEG_OFFSET = sel_second ? axis_b_neg_offset_trim
        : axis_a_neg_offset_trim;

    // RULE_16 signed scale of the active sample
    always_comb
    begin
        nxt_scaled = $signed(I_SAMPLE) * $signed(sel_second
            ? axis_b_digital_gain : axis_a_digital_gain);
    end

    always_ff @(posedge I_MCLK)
    begin
        if (!I_RESETN)
        begin
            scaled_ff <= 44'h00000000000;
            scaled_valid_ff <= 1'b0;
        end
        else
        begin
            scaled_valid_ff <= I_SAMPLE_VALID;
            if (I_SAMPLE_VALID)
            begin
                scaled_ff <= nxt_scaled;
            end
        end
    end

    // Output drive
    assign O_RDATA = rdata_ff;
    assign O_RVALID = rvalid_ff;
    assign O_SCALED = scaled_ff;
    assign O_SCALED_VALID = scaled_valid_ff;
    assign O_AXIS_SECOND = sel_second;
    assign O_EXC_LOW_MODE = exc_low_ff;
    assign O_EXC_REF_TRIM = exc_trim_ff;
    assign O_COMP_BYTE_1 = parasitic_comp_byte_1;
    assign O_COMP_BYTE_2 = parasitic_comp_byte_2;
    assign O_COMP_BYTE_3 = parasitic_comp_byte_3;
    assign O_COMP_BYTE_4 = parasitic_comp_byte_4;
endmodule
`default_nettype wire

//--- testbench/cvr_config_regs_sva.sv
// Port-level checker for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
module cvr_config_regs_chk
import cvr_pkg::*;
(
    // Clock, reset and register port
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [5:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic [31:0] O_RDATA,
    input wire logic O_RVALID,
    // Sample path and applied settings
    input wire logic I_SAMPLE_VALID,
    input wire logic O_SCALED_VALID,
    input wire logic O_AXIS_SECOND,
    input wire logic O_EXC_LOW_MODE,
    input wire logic [3:0] O_EXC_REF_TRIM,
    input wire logic [3:0] O_GAIN1,
    input wire logic [2:0] O_GAIN2,
    input wire logic [3:0] O_BANDWIDTH,
    input wire logic [7:0] O_COMP_BYTE_1,
    input wire logic [7:0] O_COMP_BYTE_2,
    input wire logic [7:0] O_COMP_BYTE_3,
    input wire logic [7:0] O_COMP_BYTE_4
);
    // One domain, so reset silences every check
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESETN);
    // ------------------------------------------
    // Register port and sample path
    // ------------------------------------------
    rd_answer_a:
        assert property (O_RVALID == $past(I_RD)) else $error("bad rvalid");
    rdata_hold_a:
        assert property (!$past(I_RD) |-> $stable(O_RDATA))
        else $error("rdata moved");
    scale_valid_a:
        assert property (O_SCALED_VALID == $past(I_SAMPLE_VALID))
        else $error("bad scaled valid");
    // ------------------------------------------
    // Applied settings follow the writes
    // ------------------------------------------
    axis_code_a:
        assert property (I_WR && I_ADDR == ADDR_AXIS_SEL |=>
            O_AXIS_SECOND == ($past(I_WDATA[19:18]) == AXIS_SECOND))
        else $error("axis select wrong");
    low_follow_a:
        assert property (I_WR && I_ADDR == ADDR_LOW_EXC |=> ##1
            O_EXC_LOW_MODE == $past(I_WDATA[30], 2))
        else $error("low mode lag wrong");
    low_blocks_a:
        assert property (O_EXC_LOW_MODE |-> O_EXC_REF_TRIM == 4'h0)
        else $error("trim not blocked");
    comp_hi_a:
        assert property (I_WR && I_ADDR == ADDR_B_NEG_OFS |=>
            {O_COMP_BYTE_1, O_COMP_BYTE_2} == $past(I_WDATA[31:16]))
        else $error("comp bytes 1 2 wrong");
    comp_lo_a:
        assert property (I_WR && I_ADDR == ADDR_COMP_LO |=>
            {O_COMP_BYTE_3, O_COMP_BYTE_4} == $past(I_WDATA[15:0]))
        else $error("comp bytes 3 4 wrong");
    gain_a_sel_a:
        assert property (I_WR && I_ADDR == ADDR_A_GAIN && !O_AXIS_SECOND |=>
            {O_GAIN2, O_GAIN1} == $past(I_WDATA[28:22]))
        else $error("axis one gains wrong");
    bw_b_sel_a:
        assert property (I_WR && I_ADDR == ADDR_B_BW && O_AXIS_SECOND |=>
            O_BANDWIDTH == $past(I_WDATA[7:4]))
        else $error("axis two bandwidth wrong");
endmodule
bind cvr_config_regs cvr_config_regs_chk chk (.*);
`default_nettype wire

//--- testbench/cvr_host_model.sv
// Host model programming the bank over its register port
`timescale 1ns/1ns
`default_nettype none
module cvr_host_model
import cvr_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Register port toward the bank
    output logic o_wr,
    output logic o_rd,
    output logic [5:0] o_addr,
    output logic [31:0] o_wdata,
    input wire logic [31:0] i_rdata,
    input wire logic i_rvalid
);
    // Idle at time zero
    initial
    begin
        {o_wr, o_rd, o_addr, o_wdata} = '0;
    end
    // Lines scrambled after release
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge i_clk);
        #1;
        {o_wr, o_addr, o_wdata} = {1'b1, a, d};
        @(posedge i_clk);
        #1;
        {o_wr, o_addr, o_wdata} = {1'b0, ~a, ~d};
    endtask
    // Read strobe, then a bounded wait for the answer
    task automatic rd(input logic [5:0] a, output logic [31:0] d,
        output bit ok);
        ok = 1'b0;
        @(posedge i_clk);
        #1;
        {o_rd, o_addr} = {1'b1, a};
        @(posedge i_clk);
        #1;
        {o_rd, o_addr} = {1'b0, ~a};
        for (int n = 0; n < 4 && !ok; n++)
        begin
            ok = (i_rvalid === 1'b1);
            d = i_rdata;
            if (!ok) @(posedge i_clk);
        end
    endtask
    task automatic rmw(input logic [5:0] a, input logic [31:0] m,
        input logic [31:0] v, output bit ok);
        logic [31:0] d;
        rd(a, d, ok);
        wr(a, (d & ~m) | (v & m));
    endtask
    task automatic sel_axis(input logic [1:0] c, output bit ok);
        logic [7:0] p;
        p = (c == AXIS_FIRST) ? 8'h36 : 8'hb6;
        wr(ADDR_AXIS_SEL, {12'h000, c, 18'h00000});
        rmw(ADDR_B_NEG_OFS, 32'hffff0000, {p, p ^ 8'h80, 16'h0000}, ok);
        wr(ADDR_COMP_LO, {16'h0000, p ^ 8'h80, p});
    endtask
    task automatic set_gain(input bit b, input logic [3:0] g1,
        input logic [2:0] g2, output bit ok);
        logic [3:0] bw;
        bw = (g1 == 4'h0) ? 4'h4 : (g1 == 4'h1) ? 4'h8 : 4'hf;
        if (b)
        begin
            rmw(ADDR_B_GAIN1, 32'h78000000, {1'b0, g1, 27'h0}, ok);
            rmw(ADDR_B_GAIN2, 32'h0000001c, {27'h0, g2, 2'h0}, ok);
            rmw(ADDR_B_BW, 32'h000000f0, {24'h0, bw, 4'h0}, ok);
        end
        else
        begin
            rmw(ADDR_A_GAIN, 32'h1fc00000, {3'h0, g2, g1, 22'h0}, ok);
            rmw(ADDR_A_BW, 32'h0f000000, {4'h0, bw, 24'h0}, ok);
        end
    endtask
endmodule
`default_nettype wire

//--- testbench/cvr_config_regs_tb_top.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
module cvr_config_regs_tb_top
import cvr_pkg::*;
;
    logic mclk, resetn, incl, wr, rd, sv, rv, scv, ax2, lowm;
    logic [5:0] addr;
    logic [31:0] wd, rdat;
    logic [23:0] smp;
    logic [43:0] scaled;
    logic [3:0] trim, g1, bw;
    logic [2:0] g2;
    logic [12:0] po, no;
    logic [7:0] c1, c2, c3, c4;
    int n_mismatch = 0;
    int n_compared = 0;
    bit ok;
    // Word indices and inclinometer defaults
    logic [5:0] da [16] = '{6'h02, 6'h09, 6'h0d, 6'h0e, 6'h0f, 6'h10,
        6'h18, 6'h1a, 6'h1c, 6'h20, 6'h24, 6'h25, 6'h28, 6'h2a, 6'h2c, 6'h3f};
    logic [31:0] di [16] = '{32'h40000000, 32'h00080000, 32'hf0, 32'h1623,
        32'h1623, 0, 32'hb1180000, 32'h1f4000, 32'h16c00000, 32'h0f000000,
        32'h1f4, 32'h58000000, 0, 32'hb1180000, 32'h14, 0};
    logic [31:0] dc [16];
    // 125 MHz clock
    always #4 mclk = ~mclk;
    cvr_config_regs dut (.I_MCLK(mclk), .I_RESETN(resetn),
        .I_VARIANT_INCL(incl), .I_WR(wr), .I_RD(rd), .I_ADDR(addr),
        .I_WDATA(wd), .O_RDATA(rdat), .O_RVALID(rv), .I_SAMPLE_VALID(sv),
        .I_SAMPLE(smp), .O_SCALED_VALID(scv), .O_SCALED(scaled),
        .O_AXIS_SECOND(ax2), .O_EXC_LOW_MODE(lowm), .O_EXC_REF_TRIM(trim),
        .O_GAIN1(g1), .O_GAIN2(g2), .O_BANDWIDTH(bw), .O_POS_OFFSET(po),
        .O_NEG_OFFSET(no), .O_COMP_BYTE_1(c1), .O_COMP_BYTE_2(c2),
        .O_COMP_BYTE_3(c3), .O_COMP_BYTE_4(c4));
    cvr_host_model host (.i_clk(mclk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wd), .i_rdata(rdat), .i_rvalid(rv));
    // ------------------------------------------
    // Shared checking tasks
    // ------------------------------------------
    task automatic end_sim();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    // A lost read answer ends the run
    task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] d;
        host.rd(a, d, ok);
        if (!ok)
        begin
            n_mismatch++;
            end_sim();
        end
        chk(d, exp);
    endtask
    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    task automatic t_defaults(input logic v);
        tick();
        {resetn, incl} = {1'b0, v};
        repeat (16) @(posedge mclk);
        #1;
        resetn = 1'b1;
        for (int i = 0; i < 16; i++)
            rdc(da[i], v ? di[i] : dc[i]);
        chk({ax2, lowm, trim, bw}, {1'b1, v, 4'h0, 4'hf});
        $display("defaults done");
    endtask
    task automatic t_axis();
        host.wr(ADDR_A_POS_OFS, 32'hffffffff);
        rdc(ADDR_A_POS_OFS, 32'hfff80000);
        host.wr(ADDR_B_POS_OFS, 32'h00000abc);
        host.set_gain(1'b0, 4'h0, 3'h3, ok);
        host.set_gain(1'b1, 4'h1, 3'h6, ok);
        host.sel_axis(AXIS_FIRST, ok);
        chk({ax2, g1, g2, bw, po}, {1'b0, 4'h0, 3'h3, 4'h4, 13'h1fff});
        chk({c1, c2, c3, c4}, 32'h36b6b636);
        host.sel_axis(AXIS_SECOND, ok);
        chk({ax2, g1, g2, bw, po}, {1'b1, 4'h1, 3'h6, 4'h8, 13'h0abc});
        chk({c1, c2, c3, c4, no}, {32'hb63636b6, 13'h1623});
        rdc(ADDR_B_GAIN2, 32'h00000018);
        $display("axis switch done");
    endtask
    task automatic t_exc();
        host.wr(ADDR_LOW_EXC, 32'h0);
        host.wr(ADDR_EXC_REF, 32'h000003c0);
        tick();
        chk({lowm, trim}, {1'b0, 4'hf});
        host.wr(ADDR_LOW_EXC, 32'h40000000);
        tick();
        chk({lowm, trim}, {1'b1, 4'h0});
        rdc(ADDR_EXC_REF, 32'h000003c0);
        $display("excitation done");
    endtask
    // Two samples back to back, then the valid drops
    task automatic t_samp(input logic [23:0] a, input logic [43:0] ea,
        input logic [23:0] b, input logic [43:0] eb);
        tick();
        {sv, smp} = {1'b1, a};
        tick();
        smp = b;
        chk({scv, scaled}, {1'b1, ea});
        tick();
        {sv, smp} = {1'b0, ~b};
        chk({scv, scaled}, {1'b1, eb});
        tick();
        chk({scv, scaled}, {1'b0, eb});
        $display("scaling done");
    endtask
    // Main sequence
    initial
    begin
        dc = di;
        {dc[0], dc[8], dc[11], dc[14]} = {32'h0, 32'h0b000000,
            32'h60000000, 32'h00000008};
        {mclk, resetn, incl, sv, smp} = '0;
        t_defaults(1'b1);
        t_axis();
        t_exc();
        t_samp(24'hfffffe, 44'hffffffffc18, 24'h7fffff, 44'h000f9fffe0c);
        host.wr(ADDR_A_DGAIN, 32'h000ffffd);
        host.sel_axis(AXIS_FIRST, ok);
        t_samp(24'h0003e8, 44'hffffffff448, 24'h800000, 44'h00001800000);
        t_defaults(1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
